//--- core/sysctl_regs.vh
/*
  constants for the system control block: mode codes, pin counts,
  strap sampling.
  assumes inclusion by bare name from design files under core/.
*/
`ifndef SYSCTL_REGS_VH
`define SYSCTL_REGS_VH

// operating modes
`define MODE_SINGLE  2'h0
`define MODE_PARTIAL 2'h1
`define MODE_FULL    2'h2
`define MODE_W       2

// pins given up by the expanded bus
`define PORT0_W      16
`define PORT1_W      16
`define P1_CTRL_LSB  8
`define PIO_LOST     5'h18

// strap classifier: samples per instruction clock pair
`define STRAP_CNT_W  3
`define STRAP_SAMPLES 3'h4
`define STRAP_ZERO   3'h0

`endif

//--- core/strap_classifier.v
/*
  strap classifier: tells a tied-high, tied-low or clock-tied mode
  strap apart by watching it for several instruction clock phases.
  assumes strap_in is sampled in the mclk_in domain and that
  phase_in is the instruction clock level the strap may be tied to.
*/
`timescale 1ns/1ns
`include "sysctl_regs.vh"

module strap_classifier (
  // clock and reset
  input wire mclk_in,
  input wire rst_b_in,
  // sampling
  input wire run_in,
  input wire strap_in,
  input wire phase_in,
  // result
  output reg [`MODE_W-1:0] mode_out
);

reg seen_hi_r;
reg seen_lo_r;
reg seen_off_r;
reg [`STRAP_CNT_W-1:0] cnt_r;
reg [`MODE_W-1:0] mode_nxt;

always @* begin
  // a strap that follows the clock has shown both levels
  // a strap that toggles out of step with the clock is not full mode
  if (seen_hi_r && seen_lo_r && !seen_off_r) begin
    mode_nxt = `MODE_FULL;
  end else if (seen_lo_r) begin
    mode_nxt = `MODE_PARTIAL;
  end else begin
    mode_nxt = `MODE_SINGLE;
  end
end

always @(posedge mclk_in or negedge rst_b_in) begin
  if (!rst_b_in) begin
    seen_hi_r <= 1'b0;
    seen_lo_r <= 1'b0;
    seen_off_r <= 1'b0;
    cnt_r <= `STRAP_ZERO;
    mode_out <= `MODE_SINGLE;
  end else if (run_in) begin
    // keep watching while reset holds the core
    if (cnt_r == `STRAP_SAMPLES) begin
      mode_out <= mode_nxt;
      cnt_r <= `STRAP_ZERO;
      seen_hi_r <= 1'b0;
      seen_lo_r <= 1'b0;
      seen_off_r <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 3'h1;
      if (strap_in != phase_in) begin
        seen_off_r <= 1'b1;
      end
      if (strap_in) begin
        seen_hi_r <= 1'b1;
      end
      if (!strap_in) begin
        seen_lo_r <= 1'b1;
      end
    end
  end
end

endmodule

//--- core/sys_control.v
/*
  system control: reset release, instruction clock, non-maskable
  interrupt edge, mode strap capture and pin reassignment.
  assumes the board ties the strap high, low or to instr_clock_out,
  and that mclk_in is the time base.
*/
// Contract
// - reset overrides execution, cannot be masked
// - instruction clock is half time base
// - nmi active low, falling edge, top priority
// - nmi enabled regardless of level-one enable
// - mode strap read at power-up and reset
// - strap high single, low partial, clock full
// - expanded: port zero bus, port one control
// - expanded mode withdraws 24 parallel pins
// - internal accesses never use external bus
`timescale 1ns/1ns
`include "sysctl_regs.vh"

module sys_control (
  // clock and reset
  input wire mclk_in,
  input wire rst_b_in,
  // strap and interrupt pins
  input wire mode_strap_in,
  input wire nmi_b_in,
  // core side interrupt
  input wire level_one_irq_enable_in,
  input wire maskable_irq_in,
  input wire nmi_ack_in,
  // core side access
  input wire access_req_in,
  input wire access_internal_in,
  // clocks and resets out
  output reg instr_clock_out,
  output reg core_reset_out,
  // interrupt out
  output reg nmi_pending_out,
  output reg irq_take_out,
  // configuration out
  output reg [`MODE_W-1:0] mode_out,
  output reg expanded_out,
  output reg [`PORT0_W-1:0] port0_bus_sel_out,
  output reg [`PORT1_W-1:0] port1_ctrl_sel_out,
  output reg [4:0] pio_withdrawn_out,
  output reg ext_bus_req_out
);

////////////////////////////////////////////////////////////////////////
// reset release

reg rst_s1_r;
reg rst_s2_r;
wire rst_b;

always @(posedge mclk_in or negedge rst_b_in) begin
  if (!rst_b_in) begin
    rst_s1_r <= 1'b0;
    rst_s2_r <= 1'b0;
  end else begin
    rst_s1_r <= 1'b1;
    rst_s2_r <= rst_s1_r;
  end
end

assign rst_b = rst_s2_r;

// core held in reset while strap is classified
reg hold_r;
reg [`STRAP_CNT_W:0] hold_cnt_r;
localparam [`STRAP_CNT_W:0] HOLD_LEN = {1'b1, `STRAP_ZERO};

always @(posedge mclk_in or negedge rst_b) begin
  if (!rst_b) begin
    hold_r <= 1'b1;
    hold_cnt_r <= {(`STRAP_CNT_W+1){1'b0}};
  end else if (hold_r) begin
    hold_cnt_r <= hold_cnt_r + 4'h1;
    if (hold_cnt_r == HOLD_LEN) begin
      hold_r <= 1'b0;
    end
  end
end

always @(posedge mclk_in or negedge rst_b) begin
  if (!rst_b) begin
    // no mask term: nothing can block this path
    core_reset_out <= 1'b1;
  end else begin
    core_reset_out <= hold_r;
  end
end

////////////////////////////////////////////////////////////////////////
// instruction clock

always @(posedge mclk_in or negedge rst_b) begin
  if (!rst_b) begin
    instr_clock_out <= 1'b0;
  end else begin
    instr_clock_out <= ~instr_clock_out;
  end
end

////////////////////////////////////////////////////////////////////////
// mode strap

wire [`MODE_W-1:0] strap_mode;

strap_classifier u_strap (
  .mclk_in(mclk_in),
  .rst_b_in(rst_b),
  .run_in(hold_r),
  .strap_in(mode_strap_in),
  .phase_in(instr_clock_out),
  .mode_out(strap_mode)
);

reg expanded_nxt;

always @* begin
  expanded_nxt = (strap_mode != `MODE_SINGLE);
end

always @(posedge mclk_in or negedge rst_b) begin
  if (!rst_b) begin
    mode_out <= `MODE_SINGLE;
    expanded_out <= 1'b0;
    port0_bus_sel_out <= {`PORT0_W{1'b0}};
    port1_ctrl_sel_out <= {`PORT1_W{1'b0}};
    pio_withdrawn_out <= 5'h00;
  end else if (hold_r) begin
    // frozen once the core runs
    mode_out <= strap_mode;
    expanded_out <= expanded_nxt;
    port0_bus_sel_out <= {`PORT0_W{expanded_nxt}};
    port1_ctrl_sel_out <= expanded_nxt ?
      {{(`PORT1_W-`P1_CTRL_LSB){1'b1}}, {`P1_CTRL_LSB{1'b0}}} :
      {`PORT1_W{1'b0}};
    pio_withdrawn_out <= expanded_nxt ? `PIO_LOST : 5'h00;
  end
end

////////////////////////////////////////////////////////////////////////
// external bus request

always @(posedge mclk_in or negedge rst_b) begin
  if (!rst_b) begin
    ext_bus_req_out <= 1'b0;
  end else begin
    ext_bus_req_out <= expanded_out && !core_reset_out &&
      access_req_in && !access_internal_in;
  end
end

////////////////////////////////////////////////////////////////////////
// non-maskable interrupt

reg nmi_d_r;
wire nmi_fall;

assign nmi_fall = nmi_d_r && !nmi_b_in;

always @(posedge mclk_in or negedge rst_b) begin
  if (!rst_b) begin
    nmi_d_r <= 1'b1;
    nmi_pending_out <= 1'b0;
    irq_take_out <= 1'b0;
  end else begin
    nmi_d_r <= nmi_b_in;
    // edge wins over ack; enable bit never consulted
    if (nmi_fall) begin
      nmi_pending_out <= 1'b1;
    end else if (nmi_ack_in || core_reset_out) begin
      nmi_pending_out <= 1'b0;
    end
    // maskable request only when no nmi is waiting
    irq_take_out <= !core_reset_out && !nmi_pending_out && !nmi_fall &&
      maskable_irq_in && level_one_irq_enable_in;
  end
end

endmodule

//--- bench/board_model.sv
/* board strap wiring: high, low or tied to the clock pin.
   assumes sel_in is set before reset is released. */
`timescale 1ns/1ns
module board_model (
  // strap choice
  input wire [1:0] sel_in,
  input wire instr_clock_in,
  // strap pin
  output wire strap_out
);
  assign strap_out = (sel_in == 2'h0) | (sel_in[1] & instr_clock_in);
endmodule

//--- bench/sys_checker.sv
/* port assertions for sys_control.
   assumes it is bound into sys_control. */
`timescale 1ns/1ns
module sys_checker (
  // clock and reset
  input wire mclk_in,
  input wire rst_b_in,
  // pins in
  input wire nmi_b_in,
  input wire access_req_in,
  input wire access_internal_in,
  // outputs
  input wire instr_clock_out,
  input wire core_reset_out,
  input wire nmi_pending_out,
  input wire irq_take_out,
  input wire [1:0] mode_out,
  input wire [4:0] pio_withdrawn_out,
  input wire ext_bus_req_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  wire run = !core_reset_out;
  reset_hold_a: assert property (disable iff (1'b0)
    !rst_b_in |=> core_reset_out) else $error("core ran in reset");
  clk_half_a: assert property (
    run |=> instr_clock_out != $past(instr_clock_out)) else $error("clk");
  nmi_edge_a: assert property (
    run && $fell(nmi_b_in) |=> ##[0:1] nmi_pending_out) else $error("nmi");
  nmi_first_a: assert property (
    nmi_pending_out |-> !irq_take_out) else $error("irq beat nmi");
  mode_hold_a: assert property (
    run |=> $stable(mode_out)) else $error("mode moved");
  mode_legal_a: assert property (
    run |-> mode_out != 2'h3) else $error("bad mode");
  pio_count_a: assert property (
    run |-> pio_withdrawn_out == (mode_out != 2'h0 ? 5'h18 : 5'h00))
    else $error("pio count");
  ext_bus_a: assert property (ext_bus_req_out |-> $past(
    access_req_in & !access_internal_in & (mode_out != 2'h0)))
    else $error("bus request");
endmodule

//--- bench/testbench.sv
/* bench: boots each strap wiring, random core traffic, nmi and a
   reset in mid-run. assumes the board strap model. */
`timescale 1ns/1ns
module testbench;
  reg mclk_in = 0, rst_b_in = 0, nmi_b = 1, ack = 0;
  reg [3:0] core = 0;
  reg [1:0] sel = 0;
  reg [31:0] r;
  reg [6:0] q[$];
  reg [6:0] note;
  wire expd;
  wire [15:0] p0, p1;
  wire strap, ck, crst, pend;
  wire [1:0] mode;
  wire [4:0] pio;
  integer n_errors = 0, checks_done = 0, cyc = 0, i, k;
  integer seed = 32'hf062;
  board_model board_model_inst (.sel_in(sel), .instr_clock_in(ck),
    .strap_out(strap));
  sys_control sys_control_inst (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
    .mode_strap_in(strap), .nmi_b_in(nmi_b), .nmi_ack_in(ack),
    .level_one_irq_enable_in(core[0]), .maskable_irq_in(core[1]),
    .access_internal_in(core[2]), .access_req_in(core[3]),
    .instr_clock_out(ck), .core_reset_out(crst), .nmi_pending_out(pend),
    .irq_take_out(), .mode_out(mode), .expanded_out(expd),
    .port0_bus_sel_out(p0), .port1_ctrl_sel_out(p1),
    .pio_withdrawn_out(pio), .ext_bus_req_out());
  initial forever #10 mclk_in = ~mclk_in;
  task check(input [15:0] s, input [15:0] e);
    begin
      checks_done = checks_done + 1;
      if (s !== e) begin
        n_errors = n_errors + 1;
        $display("Error at %0t: saw %h want %h", $time, s, e);
      end
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  always @(posedge mclk_in) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      n_errors = n_errors + 1;
      stop_test;
    end
  end
  always @(negedge crst) begin
    #1 note = q.pop_front();
    check({mode, pio}, note);
    check(expd, note[6:5] != 2'h0);
    check(p0, {16{note[6:5] != 2'h0}});
    check(p1, (note[6:5] != 2'h0) ? 16'hff00 : 16'h0000);
  end
  initial begin
    for (k = 0; k < 3; k = k + 1) begin
      sel = k;
      nmi_b = 1;
      rst_b_in = 0;
      repeat (5) @(negedge mclk_in);
      q.push_back({sel, sel ? 5'h18 : 5'h00});
      rst_b_in = 1;
      for (i = 0; i < 40 && crst !== 1'b0; i = i + 1) @(negedge mclk_in);
      // strap moves while running; the captured mode must not
      sel = sel + 2'h1;
      for (i = 0; i < 40; i = i + 1) begin
        @(negedge mclk_in);
        r = $random(seed);
        core = r[3:0];
      end
      core = 4'h2;
      nmi_b = 0;
      repeat (2) @(negedge mclk_in);
      check({6'h0, pend}, 7'h1);
      ack = 1;
      @(negedge mclk_in);
      ack = 0;
      nmi_b = 1;
      @(negedge mclk_in);
      check({6'h0, pend}, 7'h0);
      nmi_b = 0;
      repeat (2) @(negedge mclk_in);
      #3 rst_b_in = 0;
      #1 check({5'h0, crst, pend}, 7'h2);
      $display("test mode %0d done", k);
    end
    stop_test;
  end
endmodule
bind sys_control sys_checker sys_checker_inst (.*);
